// file: verilog/spectral_defines.svh
`ifndef SPECTRAL_DEFINES_SVH
`define SPECTRAL_DEFINES_SVH
// ----------------------------------------
// Mailbox registers and bus address
// ----------------------------------------
`define MBX_STATUS_OFS 2'h0
`define MBX_INBOX_OFS 2'h1
`define MBX_OUTBOX_OFS 2'h2
`define MBX_INBOX_FULL_BIT 1
`define MBX_OUTBOX_FULL_BIT 0
`define SLAVE_ADDR7 7'h49
`define VWRITE_MARK_BIT 7
// ----------------------------------------
// Virtual registers
// ----------------------------------------
`define VREG_CONTROL 7'h04
`define VREG_INTEG 7'h05
`define VREG_LED 7'h07
`define VREG_DATA_FIRST 7'h08
`define VREG_DATA_LAST 7'h13
`define CTL_TRIG_BIT 0
`define CTL_RDY_BIT 1
`define CTL_BANK_LSB 2
`define CTL_GAIN_LSB 4
`define CTL_INT_BIT 6
`define CTL_RESET 8'h00
`define INTEG_RESET 8'hFF
`define LED_RESET 8'h00
`define IND_ON_BIT 0
`define IND_CUR_LSB 1
`define SHUT_ON_BIT 3
`define SHUT_CUR_LSB 4
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_KHZ 10000
`define INTEG_STEP_US 2800
`define BLINK_MS 500
`define EXT_RESET_MS 100
`endif

// file: verilog/spectral_pkg.sv
package spectral_pkg;
    typedef enum logic [1:0] {BANK_ONE, BANK_TWO, BANK_ALL, BANK_SINGLE} bank_e;
    typedef enum {CV_IDLE, CV_FIRST, CV_SECOND} conv_e;
    typedef enum {BS_IDLE, BS_ADDR, BS_WR, BS_ACK, BS_RD, BS_RACK} bus_e;
    typedef struct packed {
        logic [15:0] ch_a;
        logic [15:0] ch_b;
        logic [15:0] ch_c;
        logic [15:0] ch_d;
        logic [15:0] ch_e;
        logic [15:0] ch_f;
    } chan_set_s;
    typedef struct packed {
        logic [1:0] ind_cur;
        logic [1:0] drv_cur;
    } led_cur_s;
endpackage : spectral_pkg

// file: verilog/spectral_conversion_i2c_mailbox.sv
`timescale 1ns/1ps
`include "spectral_defines.svh"
// What this block does
// R1 - Group 0 fills b,c,d,e; a,f zero
// R2 - Group 1 fills a,c,d,f; others zero
// R3 - Group 2 fills all; groups 0-2 continuous
// R4 - Two banks; period at least 2.8 ms
// R5 - Ready after one or two periods
// R6 - Writing group 3 starts two conversions
// R7 - Single capture runs on trigger; cleared at ready
// R8 - Host rewrites group 3 for each capture
// R9 - Interrupt enabled: ready pulls line low
// R10 - Control register read releases interrupt
// R11 - Any result read clears ready flag
// R12 - Second result byte held after first
// R13 - Unread results: line low, data replaced
// R14 - External reset held low over 100 ms
// R15 - Indicator blinks 500 ms while programming
// R16 - LED currents selectable, outputs switchable
// R17 - Bus address 1001 001x, standard/fast
// R18 - Status at 0: inbox bit1, outbox bit0
// R19 - Inbox at 1 written, outbox at 2 read
// R20 - Address bit 7 marks virtual write
// R21 - Master polls inbox before each byte
// R22 - Virtual read address sent unmodified
// R23 - Master polls outbox full then reads
// R24 - Multi-byte values big endian
// R25 - Inbox consumed, outbox flags tracked
module spectral_conversion_i2c_mailbox import spectral_pkg::*; #(
    parameter int STEP_CYC = `INTEG_STEP_US * `CLK_KHZ / 1000,
    parameter int BLINK_CYC = `BLINK_MS * `CLK_KHZ
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Device pins
    input wire logic ext_reset_n,
    input wire logic host_if_select,
    input wire logic prog_busy,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Front end results
    input wire chan_set_s adc_data,
    // Device outputs
    output logic int_n,
    output logic indicator_led_out,
    output logic shutter_led_out,
    output led_cur_s led_cur
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] pin_m_r, pin_s_r;
    logic scl_d_r, sda_d_r, rst_i;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_m_r <= 5'h1F;
            pin_s_r <= 5'h1F;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (ce) begin
            pin_m_r <= {ext_reset_n, host_if_select, prog_busy, scl_in, sda_in};
            pin_s_r <= pin_m_r;
            scl_d_r <= pin_s_r[1];
            sda_d_r <= pin_s_r[0];
        end
    end
    // Pin level shorter than the reset time is left to the outside controller [R14]
    assign rst_i = rst | ~pin_s_r[4];
    wire scl = pin_s_r[1];
    wire sda = pin_s_r[0];
    wire scl_rise = scl & ~scl_d_r;
    wire scl_fall = ~scl & scl_d_r;
    wire bus_start = scl & scl_d_r & sda_d_r & ~sda & pin_s_r[3];
    wire bus_stop = scl & scl_d_r & ~sda_d_r & sda;

    // ----------------------------------------
    // Registers and flags
    // ----------------------------------------
    logic [7:0] ctl_r, integ_r, led_r, inbox_r, outbox_r, shadow_r, vdata;
    logic inbox_full_r, outbox_full_r, wr_pend_r, int_n_r;
    logic [6:0] wr_addr_r;
    chan_set_s res_r;
    logic [15:0] res_w [6];
    conv_e cv_r;
    bus_e bs_r;
    logic [7:0] sh_r, tx_r, stat_byte;
    logic [3:0] cnt_r;
    logic [1:0] ptr_r;
    logic rw_r, first_r, drv_r, inbox_wr, outbox_rd;
    logic [23:0] tmr_r;
    logic rdy_evt, restart;
    wire bank_e bank = bank_e'(ctl_r[`CTL_BANK_LSB +: 2]);
    assign res_w = '{res_r.ch_a, res_r.ch_b, res_r.ch_c, res_r.ch_d, res_r.ch_e, res_r.ch_f};
    assign stat_byte = {6'h00, inbox_full_r, outbox_full_r}; // [R18]

    // ----------------------------------------
    // Serial slave
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst_i) begin
            bs_r <= BS_IDLE;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            cnt_r <= 4'h0;
            ptr_r <= 2'h0;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            drv_r <= 1'b0;
        end else if (ce) begin
            if (bus_start) begin
                bs_r <= BS_ADDR;
                cnt_r <= 4'h0;
                drv_r <= 1'b0;
            end else if (bus_stop) begin
                bs_r <= BS_IDLE;
                drv_r <= 1'b0;
            end else begin
                unique case (bs_r)
                    BS_IDLE: begin
                    end
                    BS_ADDR, BS_WR: begin
                        if (scl_rise) begin
                            sh_r <= {sh_r[6:0], sda};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == 4'h8) begin
                            if (bs_r == BS_WR) begin
                                drv_r <= 1'b1;
                                bs_r <= BS_ACK;
                                first_r <= 1'b0;
                                if (first_r) ptr_r <= sh_r[1:0];
                            end else if (sh_r[7:1] == `SLAVE_ADDR7) begin // [R17]
                                drv_r <= 1'b1;
                                rw_r <= sh_r[0];
                                first_r <= ~sh_r[0];
                                bs_r <= BS_ACK;
                            end else begin
                                bs_r <= BS_IDLE;
                            end
                        end
                    end
                    BS_ACK, BS_RACK: begin
                        if (scl_rise && bs_r == BS_RACK && sda) bs_r <= BS_IDLE;
                        else if (scl_fall) begin
                            cnt_r <= 4'h0;
                            if (rw_r) begin
                                tx_r <= (ptr_r == `MBX_OUTBOX_OFS) ? outbox_r : stat_byte;
                                drv_r <= (ptr_r == `MBX_OUTBOX_OFS) ? ~outbox_r[7] : ~stat_byte[7];
                                bs_r <= BS_RD;
                            end else begin
                                drv_r <= 1'b0;
                                bs_r <= BS_WR;
                            end
                        end
                    end
                    BS_RD: begin
                        if (scl_fall) begin
                            cnt_r <= cnt_r + 4'h1;
                            tx_r <= {tx_r[6:0], 1'b0};
                            drv_r <= (cnt_r == 4'h7) ? 1'b0 : ~tx_r[6];
                            if (cnt_r == 4'h7) bs_r <= BS_RACK;
                        end
                    end
                endcase
            end
        end
    end
    // Inbox write ignored while occupied; master is meant to poll first [R21]
    assign inbox_wr = ce && bs_r == BS_WR && scl_fall && cnt_r == 4'h8 && !first_r
        && ptr_r == `MBX_INBOX_OFS && !inbox_full_r; // [R19]
    assign outbox_rd = ce && (bs_r == BS_ACK || bs_r == BS_RACK) && scl_fall && rw_r
        && ptr_r == `MBX_OUTBOX_OFS; // [R19]

    always_ff @(posedge clk_sys) begin
        if (rst_i) begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (ce) begin
            sda_oe_n <= ~drv_r;
        end
    end

    // ----------------------------------------
    // Virtual register engine
    // ----------------------------------------
    // Reads wait while the outbox still holds a byte, so none is overwritten
    wire consume = inbox_full_r && !outbox_full_r;
    wire vrd = consume && !wr_pend_r && !inbox_r[`VWRITE_MARK_BIT]; // [R20] [R22]
    wire vwr = consume && wr_pend_r;
    wire [6:0] vaddr = inbox_r[6:0];
    wire ctl_rd = vrd && vaddr == `VREG_CONTROL;
    wire data_rd = vrd && vaddr >= `VREG_DATA_FIRST && vaddr <= `VREG_DATA_LAST;
    wire hi_rd = data_rd && !vaddr[0];
    wire ctl_wr = vwr && wr_addr_r == `VREG_CONTROL;
    wire [6:0] didx = vaddr - `VREG_DATA_FIRST;

    always_comb begin
        vdata = 8'h00;
        if (vaddr == `VREG_CONTROL) vdata = {1'b0, ctl_r[6:0]};
        else if (vaddr == `VREG_INTEG) vdata = integ_r;
        else if (vaddr == `VREG_LED) vdata = led_r;
        else if (data_rd) begin
            // High byte first at the lower address; low byte from the shadow [R24] [R12]
            vdata = vaddr[0] ? shadow_r : res_w[didx[3:1]][15:8];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst_i) begin
            inbox_r <= 8'h00;
            inbox_full_r <= 1'b0;
            outbox_r <= 8'h00;
            outbox_full_r <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 7'h00;
            shadow_r <= 8'h00;
        end else if (ce) begin
            if (inbox_wr) begin
                inbox_r <= sh_r;
                inbox_full_r <= 1'b1;
            end else if (consume) begin
                inbox_full_r <= 1'b0; // [R25]
            end
            if (consume && !wr_pend_r && inbox_r[`VWRITE_MARK_BIT]) begin
                wr_pend_r <= 1'b1; // [R20]
                wr_addr_r <= vaddr;
            end else if (vwr) begin
                wr_pend_r <= 1'b0;
            end
            if (vrd) begin
                outbox_r <= vdata;
                outbox_full_r <= 1'b1; // [R25]
            end else if (outbox_rd) begin
                outbox_full_r <= 1'b0; // [R25]
            end
            if (hi_rd) shadow_r <= res_w[didx[3:1]][7:0]; // [R12]
        end
    end

    // ----------------------------------------
    // Control, integration and LED registers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst_i) begin
            ctl_r <= `CTL_RESET;
            integ_r <= `INTEG_RESET;
            led_r <= `LED_RESET;
        end else if (ce) begin
            if (ctl_wr) begin
                ctl_r[7:2] <= {1'b0, inbox_r[6:2]};
                // Each write of group 3 arms a capture unless rdy_evt fires in the same cycle [R6] [R8]
                ctl_r[`CTL_TRIG_BIT] <= inbox_r[`CTL_TRIG_BIT]
                    | (inbox_r[`CTL_BANK_LSB +: 2] == 2'(BANK_SINGLE));
            end
            if (rdy_evt) begin
                ctl_r[`CTL_RDY_BIT] <= 1'b1; // [R9]
                ctl_r[`CTL_TRIG_BIT] <= 1'b0; // [R7]
            end else if (data_rd) begin
                ctl_r[`CTL_RDY_BIT] <= 1'b0; // [R11]
            end
            if (vwr && wr_addr_r == `VREG_INTEG) integ_r <= inbox_r;
            if (vwr && wr_addr_r == `VREG_LED) led_r <= inbox_r; // [R16]
        end
    end

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    wire [7:0] integ_eff = (integ_r == 8'h00) ? 8'h01 : integ_r;
    wire [23:0] period = 24'(int'(integ_eff) * STEP_CYC); // [R4]
    wire tmr_end = tmr_r == 24'h000001;
    wire two_bank = bank == BANK_ALL || bank == BANK_SINGLE;
    assign restart = ctl_wr;
    assign rdy_evt = ce && tmr_end && ((cv_r == CV_FIRST && !two_bank) || cv_r == CV_SECOND); // [R5]
    wire go = bank != BANK_SINGLE || ctl_r[`CTL_TRIG_BIT]; // [R3] [R7]

    always_ff @(posedge clk_sys) begin
        if (rst_i) begin
            cv_r <= CV_IDLE;
            tmr_r <= 24'h000000;
        end else if (ce) begin
            if (restart) begin
                cv_r <= CV_IDLE;
                tmr_r <= 24'h000000;
            end else begin
                unique case (cv_r)
                    CV_IDLE: begin
                        if (go) begin
                            cv_r <= CV_FIRST;
                            tmr_r <= period;
                        end
                    end
                    CV_FIRST, CV_SECOND: begin
                        if (!tmr_end) tmr_r <= tmr_r - 24'h000001;
                        else if (cv_r == CV_FIRST && two_bank) begin
                            cv_r <= CV_SECOND; // [R4]
                            tmr_r <= period;
                        end else if (bank == BANK_SINGLE) begin
                            cv_r <= CV_IDLE; // [R6]
                        end else begin
                            tmr_r <= period; // [R3] [R13]
                            cv_r <= CV_FIRST;
                        end
                    end
                endcase
            end
        end
    end

    // Slot a..f: first bank b,c,d,e; second bank a,c,d,f
    wire cap1 = ce && tmr_end && cv_r == CV_FIRST && bank != BANK_TWO;
    wire cap2 = ce && tmr_end && (cv_r == CV_SECOND || (cv_r == CV_FIRST && bank == BANK_TWO));
    localparam logic [5:0] BANK1_MASK = 6'b011110;
    localparam logic [5:0] BANK2_MASK = 6'b101101;
    wire [15:0] adc_w [6] = '{adc_data.ch_a, adc_data.ch_b, adc_data.ch_c,
        adc_data.ch_d, adc_data.ch_e, adc_data.ch_f};
    logic [15:0] slot_r [6];
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_slot
            always_ff @(posedge clk_sys) begin
                if (rst_i) begin
                    slot_r[gi] <= 16'h0000;
                end else if ((cap1 && BANK1_MASK[5-gi]) || (cap2 && BANK2_MASK[5-gi])) begin
                    slot_r[gi] <= adc_w[gi]; // [R1] [R2] [R3] [R13]
                end else if (cap1 && bank == BANK_ONE) begin
                    slot_r[gi] <= 16'h0000; // [R1]
                end else if (cap2 && bank == BANK_TWO) begin
                    slot_r[gi] <= 16'h0000; // [R2]
                end
            end
        end
    endgenerate
    assign res_r = {slot_r[0], slot_r[1], slot_r[2], slot_r[3], slot_r[4], slot_r[5]};

    // ----------------------------------------
    // Interrupt and LEDs
    // ----------------------------------------
    logic [22:0] blink_cnt_r;
    logic blink_r;
    always_ff @(posedge clk_sys) begin
        if (rst_i) begin
            int_n_r <= 1'b1;
        end else if (ce) begin
            if (rdy_evt && ctl_r[`CTL_INT_BIT]) int_n_r <= 1'b0; // [R9] [R13]
            else if (ctl_rd) int_n_r <= 1'b1; // [R10]
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst_i) begin
            blink_cnt_r <= 23'h000000;
            blink_r <= 1'b0;
        end else if (ce) begin
            if (!pin_s_r[2]) begin
                blink_cnt_r <= 23'h000000;
                blink_r <= 1'b0;
            end else if (blink_cnt_r == 23'(BLINK_CYC - 1)) begin
                blink_cnt_r <= 23'h000000;
                blink_r <= ~blink_r; // [R15]
            end else begin
                blink_cnt_r <= blink_cnt_r + 23'h000001;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst_i) begin
            int_n <= 1'b1;
            indicator_led_out <= 1'b0;
            shutter_led_out <= 1'b0;
            led_cur <= '0;
        end else if (ce) begin
            int_n <= int_n_r;
            // Programming owns the indicator; when done it follows the LED register on bit [R15]
            indicator_led_out <= pin_s_r[2] ? blink_r : led_r[`IND_ON_BIT]; // [R16]
            shutter_led_out <= led_r[`SHUT_ON_BIT]; // [R16]
            led_cur <= {led_r[`IND_CUR_LSB +: 2], led_r[`SHUT_CUR_LSB +: 2]};
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst_i);
    sequence s_first_done;
        cv_r == CV_FIRST && tmr_end && ce && !restart;
    endsequence
    property p_rdy_int;
        rdy_evt && ctl_r[`CTL_INT_BIT] |=> !int_n_r ##1 !int_n;
    endproperty
    a_rdy_int: assert property (p_rdy_int) else $error("interrupt not asserted"); // [R9]
    property p_int_rel;
        ctl_rd && !rdy_evt |=> int_n_r;
    endproperty
    a_int_rel: assert property (p_int_rel) else $error("interrupt not released"); // [R10]
    property p_rdy_clr;
        data_rd && !rdy_evt |=> !ctl_r[`CTL_RDY_BIT];
    endproperty
    a_rdy_clr: assert property (p_rdy_clr) else $error("ready not cleared"); // [R11]
    property p_trig_clr;
        rdy_evt |=> ctl_r[`CTL_RDY_BIT] && !ctl_r[`CTL_TRIG_BIT];
    endproperty
    a_trig_clr: assert property (p_trig_clr) else $error("trigger not cleared"); // [R7]
    property p_zero0;
        cap1 && bank == BANK_ONE |=> slot_r[0] == 16'h0000 && slot_r[5] == 16'h0000;
    endproperty
    a_zero0: assert property (p_zero0) else $error("group 0 slot not zero"); // [R1]
    property p_zero1;
        cap2 && bank == BANK_TWO |=> slot_r[1] == 16'h0000 && slot_r[4] == 16'h0000;
    endproperty
    a_zero1: assert property (p_zero1) else $error("group 1 slot not zero"); // [R2]
    property p_two_bank;
        s_first_done and two_bank |=> cv_r == CV_SECOND && !rdy_evt;
    endproperty
    a_two_bank: assert property (p_two_bank) else $error("second bank skipped"); // [R5]
    property p_period;
        cv_r == CV_IDLE && go && !restart && ce |=> tmr_r >= 24'(STEP_CYC);
    endproperty
    a_period: assert property (p_period) else $error("period below minimum"); // [R4]
    property p_shadow;
        hi_rd |=> shadow_r == $past(res_w[didx[3:1]][7:0]);
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow byte wrong"); // [R12]
    property p_outbox;
        vrd |=> outbox_full_r && !inbox_full_r ##1 $stable(outbox_r) [*2];
    endproperty
    a_outbox: assert property (p_outbox) else $error("outbox flags wrong"); // [R25]
endmodule : spectral_conversion_i2c_mailbox

// file: bench/i2c_master_model.sv
`timescale 1ns/1ps
`include "spectral_defines.svh"
// ----
// Serial master with mailbox polling
// ----
module i2c_master_model (
    // Clock
    input wire logic clk_sys,
    // Bus lines
    input wire logic sda_oe_n,
    output logic scl,
    output wire sda
);
    logic sda_r = 1'b1;
    // Pull-up: line high only while nobody pulls low
    assign sda = sda_r & sda_oe_n;
    initial scl = 1'b1;
    // Quarter bit of 3 cycles keeps each SCL phase at 6 cycles
    task q;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : q
    task bit_w(input logic b);
        sda_r = b;
        q;
        scl = 1'b1;
        q;
        q;
        scl = 1'b0;
        q;
    endtask : bit_w
    task bit_r(output logic b);
        sda_r = 1'b1;
        q;
        scl = 1'b1;
        q;
        b = sda;
        q;
        scl = 1'b0;
        q;
    endtask : bit_r
    task start;
        sda_r = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_r = 1'b0;
        q;
        scl = 1'b0;
        q;
    endtask : start
    task stop;
        sda_r = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_r = 1'b1;
        q;
    endtask : stop
    task byte_w(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bit_w(d[i]);
        bit_r(b);
        ack = ~b;
    endtask : byte_w
    task byte_r(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_r(d[i]);
        bit_w(last);
    endtask : byte_r
    task wr_reg(input logic [7:0] p, input logic [7:0] d);
        logic a;
        start;
        byte_w({`SLAVE_ADDR7, 1'b0}, a);
        byte_w(p, a);
        byte_w(d, a);
        stop;
    endtask : wr_reg
    task rd_reg(input logic [7:0] p, output logic [7:0] d);
        logic a;
        start;
        byte_w({`SLAVE_ADDR7, 1'b0}, a);
        byte_w(p, a);
        stop;
        start;
        byte_w({`SLAVE_ADDR7, 1'b1}, a);
        byte_r(1'b1, d);
        stop;
    endtask : rd_reg
    task poll(input int b, input logic want);
        logic [7:0] s;
        for (int i = 0; i < 40; i++) begin
            rd_reg({6'h00, `MBX_STATUS_OFS}, s);
            if (s[b] === want) break;
        end
    endtask : poll
    task vwrite(input logic [6:0] ad, input logic [7:0] dt);
        poll(`MBX_INBOX_FULL_BIT, 1'b0);
        wr_reg({6'h00, `MBX_INBOX_OFS}, {1'b1, ad});
        poll(`MBX_INBOX_FULL_BIT, 1'b0);
        wr_reg({6'h00, `MBX_INBOX_OFS}, dt);
    endtask : vwrite
    task vread(input logic [6:0] ad, output logic [7:0] dt);
        poll(`MBX_INBOX_FULL_BIT, 1'b0);
        wr_reg({6'h00, `MBX_INBOX_OFS}, {1'b0, ad});
        poll(`MBX_OUTBOX_FULL_BIT, 1'b1);
        rd_reg({6'h00, `MBX_OUTBOX_OFS}, dt);
    endtask : vread
endmodule : i2c_master_model

// file: bench/test_spectral_conversion_i2c_mailbox.sv
`timescale 1ns/1ps
`include "spectral_defines.svh"
module test_spectral_conversion_i2c_mailbox import spectral_pkg::*;;
    // ----
    // Short period so all four groups fit in one run
    // ----
    localparam int STEP = 20;
    localparam int INTEG = 100;
    localparam int PER = STEP * INTEG;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic prog_busy = 1'b0;
    logic ext_rst_n = 1'b1;
    chan_set_s adc_data = '0;
    wire scl;
    wire sda;
    logic sda_out, sda_oe_n, int_n, ind, shut, a, prev;
    led_cur_s led_cur;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int n, t0, k;
    int adc_i [6];
    int fill [4] = '{30, 45, 63, 63};
    logic [7:0] d, v;
    spectral_conversion_i2c_mailbox #(.STEP_CYC(STEP), .BLINK_CYC(16)) DUT (
        .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .ext_reset_n(ext_rst_n), .host_if_select(1'b1),
        .prog_busy(prog_busy), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .adc_data(adc_data), .int_n(int_n), .indicator_led_out(ind),
        .shutter_led_out(shut), .led_cur(led_cur)
    );
    i2c_master_model m (.clk_sys(clk_sys), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
    initial forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    // ----
    // Helpers
    // ----
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task results;
        $display("Checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task tick(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask : tick
    task wait_int;
        for (int i = 0; i < 3 * PER && int_n !== 1'b0; i++) tick(1);
    endtask : wait_int
    task set_adc;
        for (int i = 0; i < 6; i++) begin
            adc_i[i] = $urandom & 32'h0000FFFF;
            adc_data[95 - 16 * i -: 16] = adc_i[i][15:0];
        end
    endtask : set_adc
    // ----
    // Main sequence
    // ----
    initial begin
        void'($urandom(32'hBCB3AC01));
        tick(4);
        rst = 1'b0;
        tick(4);
        chk(int_n, 1'b1);
        m.rd_reg(8'h00, d);
        chk(d, 8'h00);
        m.rd_reg(8'h03, d);
        chk(d, 8'h00);
        m.start;
        m.byte_w(8'h94, a);
        m.stop;
        chk(a, 1'b0);
        $display("Test mailbox done");
        prog_busy = 1'b1;
        tick(8);
        n = 0;
        prev = ind;
        repeat (64) begin
            tick(1);
            n += (ind !== prev);
            prev = ind;
        end
        chk(n > 2 && n < 10, 1'b1);
        prog_busy = 1'b0;
        tick(8);
        chk(ind, 1'b0);
        $display("Test blink done");
        v = 8'($urandom) & 8'h3F;
        m.vwrite(`VREG_LED, v);
        chk({ind, shut, led_cur}, {v[0], v[3], v[2:1], v[5:4]});
        m.vwrite(`VREG_INTEG, 8'(INTEG));
        $display("Test led done");
        for (int md = 0; md < 4; md++) begin
            k = (md > 1) ? 2 : 1;
            set_adc;
            m.vwrite(`VREG_CONTROL, 8'h40 | 8'(md << 2));
            t0 = cyc;
            // Releases a line still low from the previous group
            m.vread(`VREG_CONTROL, d);
            wait_int;
            chk(cyc - t0 >= k * PER - 20 && cyc - t0 <= k * PER + 5, 1'b1);
            if (md < 3) begin
                set_adc;
                tick(k * PER + 20);
                chk(int_n, 1'b0);
            end
            m.vread(`VREG_CONTROL, d);
            chk(d[1:0], 2'b10);
            chk(int_n, 1'b1);
            for (int i = 0; i < 6; i++) begin
                v = ((fill[md] >> i) & 1) ? adc_i[i][15:8] : 8'h00;
                m.vread(`VREG_DATA_FIRST + 7'(2 * i), d);
                chk(d, v);
                if (i == 3) begin
                    m.vread(`VREG_DATA_FIRST + 7'(2 * i + 1), d);
                    chk(d, ((fill[md] >> i) & 1) ? adc_i[i][7:0] : 8'h00);
                end
            end
            $display("Test group %0d done", md);
        end
        m.vread(`VREG_CONTROL, d);
        chk(d[1], 1'b0);
        tick(2 * PER + 20);
        chk(int_n, 1'b1);
        $display("Test single capture idle done");
        // Pin reset mid-run must clear outputs and registers
        ext_rst_n = 1'b0;
        tick(8);
        ext_rst_n = 1'b1;
        tick(8);
        chk({ind, shut, led_cur, int_n, sda_out}, 8'h02);
        m.vread(`VREG_LED, d);
        chk(d, 8'h00);
        $display("Test pin reset done");
        results;
    end
    // Expected run is about 95k cycles
    initial begin
        #(130000 * 100);
        errors++;
        results;
    end
endmodule : test_spectral_conversion_i2c_mailbox
